// >>> usbwc_pkg.sv
package usbwc_pkg;

  // ===========================================================
  // Register map of the core's view of the block
  localparam logic [15:0] USBWC_CLOCK_WAIT_CONTROL_ADDR = 16'h008e;
  localparam logic [15:0] USBWC_MISC_CONTROL_ONE_ADDR = 16'hfff2;
  localparam logic [15:0] USBWC_USB_RANGE_BASE = 16'hfc00;

  // ===========================================================
  // Reset values
  localparam logic [7:0] USBWC_CLOCK_WAIT_CONTROL_RST = 8'h01;
  localparam logic [7:0] USBWC_MISC_CONTROL_ONE_RST = 8'h10;

  // ===========================================================
  // Field positions
  localparam int USBWC_WAIT_LSB = 0;
  localparam int USBWC_WAIT_W = 3;
  localparam int USBWC_PULLUP_CONNECT_BIT = 0;
  localparam int USBWC_TRANSCEIVER_ENABLE_N_BIT = 1;
  localparam int USBWC_ANALOG_POWER_ENABLE_BIT = 2;
  localparam int USBWC_FLASH_READ_PULSE_BIT = 4;
  localparam int USBWC_FLASH_READ_PULSE_ENABLE_BIT = 5;
  localparam logic [7:0] USBWC_MISC_IMPL_MASK = 8'h37;

  // ===========================================================
  // Controller software port map
  localparam logic [2:0] USBWC_CMD_ADDR_LO = 3'h0;
  localparam logic [2:0] USBWC_CMD_ADDR_HI = 3'h1;
  localparam logic [2:0] USBWC_CMD_WDATA = 3'h2;
  localparam logic [2:0] USBWC_CMD_GO = 3'h3;
  localparam logic [2:0] USBWC_CMD_STATUS = 3'h4;
  localparam logic [2:0] USBWC_CMD_RDATA = 3'h5;
  localparam int USBWC_GO_WRITE_BIT = 0;
  localparam int USBWC_STAT_BUSY_BIT = 0;
  localparam int USBWC_STAT_DONE_BIT = 1;
  localparam int USBWC_STAT_REFUSED_BIT = 2;

  // ===========================================================
  // States
  typedef enum logic [1:0] {
    USBWC_DEV_IDLE,
    USBWC_DEV_WAIT,
    USBWC_DEV_ACK
  } usbwc_dev_st_t;

  typedef enum logic [1:0] {
    USBWC_HOST_IDLE,
    USBWC_HOST_REQ
  } usbwc_host_st_t;

endpackage

// >>> usbwc_if.sv
`timescale 1ns/1ps
interface usbwc_if;
  // Request lines stay stable from req rising until the ack cycle
  logic req;
  logic we;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;

  modport dev (
    input req,
    input we,
    input addr,
    input wdata,
    output rdata,
    output ack
  );

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input rdata,
    input ack
  );
endinterface

// >>> usbwc_host.sv
`timescale 1ns/1ps
module usbwc_host import usbwc_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [2:0] i_sw_addr,
  input wire logic [7:0] i_sw_wdata,
  input wire logic i_sw_wr,
  input wire logic i_sw_rd,
  output logic [7:0] o_sw_rdata,
  usbwc_if.host bus
);

  // ===========================================================
  // State
  typedef struct packed {
    usbwc_host_st_t st;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic busy;
    logic done;
    logic refused;
    logic pullup_shadow;
    logic [7:0] rdata;
    logic [7:0] sw_rdata;
  } usbwc_host_state_t;

  usbwc_host_state_t s_reg;
  usbwc_host_state_t s_next;
  logic go;
  logic is_ckw;
  logic is_misc;

  // ===========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    go = i_sw_wr && i_sw_addr == USBWC_CMD_GO && !s_reg.busy;
    is_ckw = s_reg.addr == USBWC_CLOCK_WAIT_CONTROL_ADDR;
    is_misc = s_reg.addr == USBWC_MISC_CONTROL_ONE_ADDR;
    if (i_sw_wr && !s_reg.busy) begin
      case (i_sw_addr)
        USBWC_CMD_ADDR_LO: s_next.addr[7:0] = i_sw_wdata;
        USBWC_CMD_ADDR_HI: s_next.addr[15:8] = i_sw_wdata;
        USBWC_CMD_WDATA: s_next.wdata = i_sw_wdata;
        default: ;
      endcase
    end
    case (s_reg.st)
      USBWC_HOST_IDLE: begin
        if (go) begin
          s_next.we = i_sw_wdata[USBWC_GO_WRITE_BIT];
          s_next.done = 1'b0;
          // Wait-state changes only while detached from the USB host
          if (i_sw_wdata[USBWC_GO_WRITE_BIT] && is_ckw && s_reg.pullup_shadow) begin
            s_next.refused = 1'b1;
            s_next.done = 1'b1;
          end else begin
            s_next.refused = 1'b0;
            s_next.busy = 1'b1;
            s_next.st = USBWC_HOST_REQ;
          end
        end
      end
      USBWC_HOST_REQ: begin
        // Hold the request however many wait states the device adds
        if (bus.ack) begin
          s_next.st = USBWC_HOST_IDLE;
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
          if (!s_reg.we) begin
            s_next.rdata = bus.rdata;
          end
          // Track attachment; reconnecting afterwards is software's move
          if (is_misc) begin
            s_next.pullup_shadow = s_reg.we ? s_reg.wdata[USBWC_PULLUP_CONNECT_BIT]
                                            : bus.rdata[USBWC_PULLUP_CONNECT_BIT];
          end
        end
      end
      default: s_next.st = USBWC_HOST_IDLE;
    endcase
    s_next.sw_rdata = 8'h00;
    if (i_sw_rd) begin
      case (i_sw_addr)
        USBWC_CMD_ADDR_LO: s_next.sw_rdata = s_reg.addr[7:0];
        USBWC_CMD_ADDR_HI: s_next.sw_rdata = s_reg.addr[15:8];
        USBWC_CMD_WDATA: s_next.sw_rdata = s_reg.wdata;
        USBWC_CMD_STATUS: s_next.sw_rdata = {5'h00, s_reg.refused, s_reg.done, s_reg.busy};
        USBWC_CMD_RDATA: s_next.sw_rdata = s_reg.rdata;
        default: s_next.sw_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_reg <= '{st: USBWC_HOST_IDLE, addr: 16'h0000, wdata: 8'h00, we: 1'b0,
                 busy: 1'b0, done: 1'b0, refused: 1'b0, pullup_shadow: 1'b0,
                 rdata: 8'h00, sw_rdata: 8'h00};
    end else begin
      s_reg <= s_next;
    end
  end

  // ===========================================================
  // Outputs
  assign bus.req = s_reg.st == USBWC_HOST_REQ;
  assign bus.we = s_reg.we;
  assign bus.addr = s_reg.addr;
  assign bus.wdata = s_reg.wdata;
  assign o_sw_rdata = s_reg.sw_rdata;

endmodule // usbwc_host

// >>> usbwc_device.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module usbwc_device import usbwc_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  usbwc_if.dev bus,
  input wire logic [7:0] i_usb_rdata,
  output logic [15:0] o_usb_addr,
  output logic [7:0] o_usb_wdata,
  output logic o_usb_wr,
  output logic o_usb_rd,
  output logic o_transceiver_enable_n,
  output logic o_pullup_connect,
  output logic o_flash_read_pulse_enable,
  output logic o_flash_read_pulse,
  output logic o_analog_power_enable,
  output logic [2:0] o_wait_state_count
);

  // ===========================================================
  // State
  typedef struct packed {
    usbwc_dev_st_t st;
    logic [USBWC_WAIT_W-1:0] cnt;
    logic [USBWC_WAIT_W-1:0] wait_state_count;
    logic [7:0] misc;
    logic [7:0] rdata;
  } usbwc_dev_state_t;

  usbwc_dev_state_t s_reg;
  usbwc_dev_state_t s_next;

  logic hit_ckw;
  logic hit_misc;
  logic hit_usb;
  logic access;
  logic [7:0] rd_val;

  // ===========================================================
  // Address decode
  // The misc register sits inside the USB window, so it is
  // stretched like any other USB register.
  always_comb begin
    hit_ckw = bus.addr == USBWC_CLOCK_WAIT_CONTROL_ADDR;
    hit_misc = bus.addr == USBWC_MISC_CONTROL_ONE_ADDR;
    hit_usb = bus.addr >= USBWC_USB_RANGE_BASE;
  end

  // ===========================================================
  // Read mux
  always_comb begin
    rd_val = 8'h00;
    if (hit_ckw) begin
      // Upper five bits are unused and read as zero
      rd_val = {5'h00, s_reg.wait_state_count};
    end else if (hit_misc) begin
      rd_val = s_reg.misc & USBWC_MISC_IMPL_MASK;
    end else if (hit_usb) begin
      rd_val = i_usb_rdata;
    end
  end

  // ===========================================================
  // Access sequencer
  // A request is taken in IDLE. Accesses outside the USB window
  // complete at once; inside it the sequencer first spends the
  // programmed number of cycles in WAIT. The count is sampled
  // when the request is taken, so a change of the field only
  // affects later accesses.
  always_comb begin
    s_next = s_reg;
    access = 1'b0;
    case (s_reg.st)
      USBWC_DEV_IDLE: begin
        if (bus.req) begin
          if (hit_usb && s_reg.wait_state_count != 3'h0) begin
            s_next.st = USBWC_DEV_WAIT;
            s_next.cnt = s_reg.wait_state_count;
          end else begin
            access = 1'b1;
          end
        end
      end
      USBWC_DEV_WAIT: begin
        s_next.cnt = s_reg.cnt - 3'h1;
        if (s_reg.cnt == 3'h1) begin
          access = 1'b1;
        end
      end
      USBWC_DEV_ACK: begin
        // Ack cycle; the request is still high here and is ignored
        s_next.st = USBWC_DEV_IDLE;
      end
      default: s_next.st = USBWC_DEV_IDLE;
    endcase

    if (access) begin
      s_next.st = USBWC_DEV_ACK;
      s_next.rdata = bus.we ? 8'h00 : rd_val;
      if (bus.we && hit_ckw) begin
        s_next.wait_state_count = bus.wdata[USBWC_WAIT_LSB +: USBWC_WAIT_W];
      end
      if (bus.we && hit_misc) begin
        // Unused bits never store, so they can not read back set
        s_next.misc = bus.wdata & USBWC_MISC_IMPL_MASK;
      end
    end
  end

  // ===========================================================
  // State register
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_reg.st <= USBWC_DEV_IDLE;
      s_reg.cnt <= 3'h0;
      s_reg.wait_state_count <= USBWC_CLOCK_WAIT_CONTROL_RST[USBWC_WAIT_W-1:0];
      s_reg.misc <= USBWC_MISC_CONTROL_ONE_RST;
      s_reg.rdata <= 8'h00;
    end else begin
      s_reg <= s_next;
    end
  end

  // ===========================================================
  // Core side
  assign bus.ack = s_reg.st == USBWC_DEV_ACK;
  assign bus.rdata = s_reg.rdata;

  // ===========================================================
  // USB engine side
  // Strobes fire in the single access cycle, after the waits, so
  // the engine never sees a request it cannot keep up with.
  assign o_usb_addr = bus.addr;
  assign o_usb_wdata = bus.wdata;
  assign o_usb_wr = access && bus.we && hit_usb && !hit_misc;
  assign o_usb_rd = access && !bus.we && hit_usb && !hit_misc;

  // ===========================================================
  // Control outputs
  assign o_transceiver_enable_n = s_reg.misc[USBWC_TRANSCEIVER_ENABLE_N_BIT];
  assign o_pullup_connect = s_reg.misc[USBWC_PULLUP_CONNECT_BIT];
  assign o_flash_read_pulse_enable = s_reg.misc[USBWC_FLASH_READ_PULSE_ENABLE_BIT];
  assign o_flash_read_pulse = s_reg.misc[USBWC_FLASH_READ_PULSE_BIT];
  assign o_analog_power_enable = s_reg.misc[USBWC_ANALOG_POWER_ENABLE_BIT];
  assign o_wait_state_count = s_reg.wait_state_count;

endmodule // usbwc_device

// >>> usbwc_checker.sv
`timescale 1ns/1ps
// ====
// Bus timing watcher
module usbwc_checker import usbwc_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [15:0] i_addr,
  input wire logic i_ack,
  input wire logic i_usb_rd,
  input wire logic i_usb_wr,
  input wire logic [2:0] i_wait_state_count
);
  logic [3:0] cnt_reg;
  logic [3:0] need_reg;
  // Wait count is captured on the take edge, as the device samples it there
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= 4'h0;
      need_reg <= 4'h0;
    end else if (i_ack || !i_req) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg == 4'h0) begin
        need_reg <= (i_addr >= USBWC_USB_RANGE_BASE) ?
                    {1'b0, i_wait_state_count} + 4'h1 : 4'h1;
      end
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  a_ack_latency: assert property (i_ack |-> cnt_reg == need_reg)
    else $error("ack latency wrong");
  a_no_hang: assert property (i_req |-> cnt_reg <= 4'h8)
    else $error("access too long");
  a_ack_pulse: assert property (i_ack |=> !i_ack) else $error("ack too long");
  a_ack_in_req: assert property (i_ack |-> i_req) else $error("ack without request");
  a_req_hold: assert property (i_req && !i_ack |=> i_req && $stable(i_addr) && $stable(i_we))
    else $error("request changed early");
  a_req_drop: assert property (i_ack |=> !i_req) else $error("request not dropped");
  a_strobe_map: assert property ((i_usb_rd || i_usb_wr) |->
    i_req && i_addr >= USBWC_USB_RANGE_BASE && i_addr != USBWC_MISC_CONTROL_ONE_ADDR &&
    i_usb_wr == i_we)
    else $error("strobe outside range");
  a_strobe_ack: assert property ((i_usb_rd || i_usb_wr) |=> i_ack)
    else $error("strobe not before ack");
  c_max_wait: cover property (i_ack && cnt_reg == 4'h8);
  c_usb_wr: cover property (i_usb_wr);
  c_usb_rd: cover property (i_usb_rd);
  c_ckc_ack: cover property (i_ack && i_addr == USBWC_CLOCK_WAIT_CONTROL_ADDR);
endmodule // usbwc_checker

// >>> tb_usb_sfr_wait_and_connect_ctrl.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_usb_sfr_wait_and_connect_ctrl;
  import usbwc_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic [2:0] sw_addr;
  logic [7:0] sw_wdata;
  logic sw_wr;
  logic sw_rd;
  logic [7:0] sw_rdata;
  logic [7:0] usb_rdata;
  logic [15:0] usb_addr;
  logic [7:0] usb_wdata;
  logic usb_wr;
  logic usb_rd;
  logic txen_n, pull, frpe, frp, ana;
  logic [2:0] wcnt;
  logic [7:0] last_w;
  logic [7:0] stat;
  logic [7:0] q;
  int n_errors = 0;
  int checked = 0;
  always #20 i_clk_sys = ~i_clk_sys;
  // ====
  // Both ends joined
  usbwc_if bus_if ();
  usbwc_host usbwc_host_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_sw_addr(sw_addr),
    .i_sw_wdata(sw_wdata), .i_sw_wr(sw_wr), .i_sw_rd(sw_rd), .o_sw_rdata(sw_rdata),
    .bus(bus_if.host));
  usbwc_device usbwc_device_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .bus(bus_if.dev),
    .i_usb_rdata(usb_rdata), .o_usb_addr(usb_addr), .o_usb_wdata(usb_wdata),
    .o_usb_wr(usb_wr), .o_usb_rd(usb_rd), .o_transceiver_enable_n(txen_n),
    .o_pullup_connect(pull), .o_flash_read_pulse_enable(frpe), .o_flash_read_pulse(frp),
    .o_analog_power_enable(ana), .o_wait_state_count(wcnt));
  usbwc_checker usbwc_checker_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_req(bus_if.req), .i_we(bus_if.we), .i_addr(bus_if.addr), .i_ack(bus_if.ack),
    .i_usb_rd(usb_rd), .i_usb_wr(usb_wr), .i_wait_state_count(wcnt));
  // Engine answers at once, with data tied to the address
  assign usb_rdata = usb_addr[7:0] ^ 8'h5a;
  always @(posedge i_clk_sys) if (usb_wr) last_w <= usb_wdata;
  // ====
  // Software port access
  task sw_w(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge i_clk_sys);
    sw_wr <= 1'b0;
  endtask
  task sw_r(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge i_clk_sys);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    sw_w(USBWC_CMD_ADDR_LO, a[7:0]);
    sw_w(USBWC_CMD_ADDR_HI, a[15:8]);
    sw_w(USBWC_CMD_WDATA, d);
    sw_w(USBWC_CMD_GO, {7'h0, w});
    stat = 8'h0;
    for (int i = 0; i < 30 && stat[USBWC_STAT_DONE_BIT] !== 1'b1; i++) sw_r(USBWC_CMD_STATUS, stat);
    sw_r(USBWC_CMD_RDATA, q);
  endtask
  task conclude;
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    n_errors++;
    conclude;
  end
  // ====
  // Scenarios
  initial begin
    sw_addr <= 3'h0;
    sw_wdata <= 8'h00;
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    repeat (10) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    #1 `CHK("outs rst", 8'h11, {txen_n, pull, frpe, frp, ana, wcnt})
    acc(1'b0, USBWC_CLOCK_WAIT_CONTROL_ADDR, 8'h00);
    `CHK("ckc rst", 8'h01, q)
    acc(1'b0, USBWC_MISC_CONTROL_ONE_ADDR, 8'h00);
    `CHK("misc rst", 8'h10, q)
    acc(1'b1, USBWC_MISC_CONTROL_ONE_ADDR, 8'hff);
    acc(1'b0, USBWC_MISC_CONTROL_ONE_ADDR, 8'h00);
    `CHK("misc rb", 8'h37, q)
    `CHK("misc outs", 5'h1f, {txen_n, pull, frpe, frp, ana})
    acc(1'b1, USBWC_CLOCK_WAIT_CONTROL_ADDR, 8'h05);
    `CHK("refused", 3'h6, stat[2:0])
    `CHK("wcnt kept", 3'h1, wcnt)
    acc(1'b1, USBWC_MISC_CONTROL_ONE_ADDR, 8'h00);
    `CHK("detach", 5'h00, {txen_n, pull, frpe, frp, ana})
    for (int n = 0; n < 8; n++) begin
      acc(1'b1, USBWC_CLOCK_WAIT_CONTROL_ADDR, {5'h1f, n[2:0]});
      acc(1'b0, USBWC_CLOCK_WAIT_CONTROL_ADDR, 8'h00);
      `CHK("ckc rb", {5'h00, n[2:0]}, q)
      `CHK("wcnt", n[2:0], wcnt)
      acc(1'b0, 16'hfc10 + n[15:0], 8'h00);
      `CHK("usb rd", (8'h10 + n[7:0]) ^ 8'h5a, q)
      acc(1'b1, 16'hfc20, 8'ha0 + n[7:0]);
      `CHK("usb wr", 8'ha0 + n[7:0], last_w)
      acc(1'b0, 16'h0010, 8'h00);
      `CHK("unmapped", 8'h00, q)
    end
    acc(1'b1, USBWC_MISC_CONTROL_ONE_ADDR, 8'h01);
    `CHK("reconnect", 5'h08, {txen_n, pull, frpe, frp, ana})
    sw_r(USBWC_CMD_ADDR_HI, q);
    `CHK("addr hi rb", 8'hff, q)
    sw_r(USBWC_CMD_WDATA, q);
    `CHK("wdata rb", 8'h01, q)
    @(posedge i_clk_sys);
    i_rst_b <= 1'b0;
    @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    #1 `CHK("rerst", 8'h11, {txen_n, pull, frpe, frp, ana, wcnt})
    acc(1'b0, USBWC_MISC_CONTROL_ONE_ADDR, 8'h00);
    `CHK("misc rerst", 8'h10, q)
    conclude;
  end
endmodule // tb_usb_sfr_wait_and_connect_ctrl
